// File: design/bse_core.sv
// tester status, latched events, counters and single error insertion
// assumes control bits and pattern checker results arrive on core_clk_i;
// the external insert and remote update pins are asynchronous
// the host lowers the sw insert bit before each new request
// clk_en_i low freezes every register, strobes included
module bse_core
(
  // clock, synchronous reset and run enable
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  // read data holds until the next read strobe
  output logic [7:0] reg_rdata_o,
  // control byte from the insertion control register
  input wire logic [7:0] insert_ctrl_i,
  input wire logic ext_error_insert_input_i,
  // update request control
  input wire logic update_request_source_i,
  input wire logic local_update_request_i,
  input wire logic remote_update_request_i,
  // transmit stream
  input wire logic tx_bit_valid_i,
  input wire logic tx_data_i,
  // outgoing bit, inverted once per armed error
  output logic tx_data_o,
  // receive checker results
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_error_i,
  input wire logic rx_out_of_sync_i,
  // level request, or of enabled latched flags
  output logic irq_o
);

  // synchronisers for the asynchronous pins
  logic [1:0] ext_sync_q;
  logic [1:0] rem_sync_q;
  // edge trackers
  logic trig_prev_q;
  // armed error waiting for the next tx bit
  logic pend_q;
  // previous update request, for its rising edge
  logic req_prev_q;
  // live status
  logic out_of_sync_q;
  logic counter_update_done_q;
  // latched flags and enables
  logic [3:0] latched_q;
  logic [3:0] irq_en_q;
  // running and snapshot counters
  logic [23:0] err_run_q;
  logic [31:0] bit_run_q;
  // snapshots are what the host reads
  logic [23:0] err_snap_q;
  logic [31:0] received_bit_count_q;
  // count status and edge history
  logic error_count_nonzero_q;
  logic errcnt_prev_q;
  logic upd_prev_q;

  // combinational helpers
  logic trig;
  logic update_req;
  logic update_rise;
  // one event bit per latched flag position
  logic [3:0] events;
  // assembled live status byte
  logic [7:0] live_byte;
  // read strobe aimed at the latched register
  logic rd_latched;

  // two-flop sync of pins
  // the first stage may go metastable, so only the second
  // stage is read by any logic below
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      ext_sync_q <= 2'h0;
      rem_sync_q <= 2'h0;
    end
    else if (clk_en_i)
    begin
      ext_sync_q <= {ext_sync_q[0], ext_error_insert_input_i};
      rem_sync_q <= {rem_sync_q[0], remote_update_request_i};
    end
  end

  // trigger mux: select 0 uses gated sw bit, 1 uses pin
  // flipping the select while either source is high can make
  // a rising edge here, which arms one error
  always_comb
  begin
    if (insert_ctrl_i[bse_pkg::BIT_SRC_SEL])
      trig = ext_sync_q[1];
    else
      trig = insert_ctrl_i[bse_pkg::BIT_SW_INS] &
             insert_ctrl_i[bse_pkg::BIT_SE_EN];
  end

  // update request source select
  // the remote pin is read only after its synchroniser; a source
  // change while the two requests differ may look like a request
  always_comb
  begin
    if (update_request_source_i)
      update_req = rem_sync_q[1];
    else
      update_req = local_update_request_i;
  end

  // one-cycle pulse on each new update request
  assign update_rise = update_req & ~req_prev_q;

  // pending error: one rising edge arms it, next tx bit spends it
  // an edge in the same cycle as a tx bit arms the following bit,
  // so no request is lost; tx_data_o holds between valid bits
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      trig_prev_q <= 1'b0;
      pend_q <= 1'b0;
      tx_data_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      trig_prev_q <= trig;
      // extra edges before the next bit collapse into one
      if (trig & ~trig_prev_q)
        pend_q <= 1'b1;
      else if (tx_bit_valid_i)
        pend_q <= 1'b0;
      // the armed error is spent on this bit
      if (tx_bit_valid_i)
        tx_data_o <= tx_data_i ^ pend_q;
    end
  end

  // sync status and update status
  // the done bit is cleared at the next edge after the request
  // drops; the live byte also masks it at once with the request
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      out_of_sync_q <= 1'b0;
      counter_update_done_q <= 1'b0;
      req_prev_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      out_of_sync_q <= rx_out_of_sync_i;
      req_prev_q <= update_req;
      // a dropped request clears done before any new rise
      if (!update_req)
        counter_update_done_q <= 1'b0;
      else if (update_rise)
        counter_update_done_q <= 1'b1;
    end
  end

  // counters: run, snapshot on update, restart
  // both counters stop at all ones instead of wrapping, and
  // neither counts while the checker reports loss of sync;
  // a bit that arrives with the update request is dropped
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      err_run_q <= 24'h00_0000;
      bit_run_q <= 32'h0000_0000;
      err_snap_q <= 24'h00_0000;
      received_bit_count_q <= 32'h0000_0000;
    end
    else if (clk_en_i)
    begin
      // an update wins over counting in the same cycle
      if (update_rise)
      begin
        err_snap_q <= err_run_q;
        received_bit_count_q <= bit_run_q;
        err_run_q <= 24'h00_0000;
        bit_run_q <= 32'h0000_0000;
      end
      // count only valid bits seen while in sync
      else if (rx_bit_valid_i && !rx_out_of_sync_i)
      begin
        if (bit_run_q != bse_pkg::BIT_MAX)
          bit_run_q <= bit_run_q + 32'h0000_0001;
        if (rx_bit_error_i && err_run_q != bse_pkg::ERR_MAX)
          err_run_q <= err_run_q + 24'h00_0001;
      end
    end
  end

  // live count status follows readable count
  // follows the snapshot, so it changes only after an update
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      error_count_nonzero_q <= 1'b0;
    else if (clk_en_i)
      error_count_nonzero_q <= (err_snap_q != 24'h00_0000);
  end

  // edge history for latched events
  // reset to the idle level of each source, so no false edge
  // follows the release of reset
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      errcnt_prev_q <= 1'b0;
      upd_prev_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      errcnt_prev_q <= error_count_nonzero_q;
      upd_prev_q <= counter_update_done_q;
    end
  end

  // event vector per flag position
  // the sync event compares the raw input with the registered
  // status, so it fires in the cycle before the status moves;
  // bit errors only count while the checker is in sync
  always_comb
  begin
    events = 4'h0;
    events[bse_pkg::BIT_SYNC] = out_of_sync_q ^ rx_out_of_sync_i;
    events[bse_pkg::BIT_ERRCNT] = error_count_nonzero_q &
                                  ~errcnt_prev_q;
    events[bse_pkg::BIT_BITERR] = rx_bit_valid_i & rx_bit_error_i &
                                  ~rx_out_of_sync_i;
    events[bse_pkg::BIT_UPDATE] = counter_update_done_q &
                                  ~upd_prev_q;
  end

  // a read of the latched register clears what it returns
  assign rd_latched = reg_rd_i && (reg_addr_i == bse_pkg::OFF_LATCHED_STATUS);

  // latched flags: set beats read clear
  // an event in the read cycle stays set for the next read,
  // so no event is lost between the read and the clear
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      latched_q <= 4'h0;
    else if (clk_en_i)
    begin
      if (rd_latched)
        latched_q <= events;
      else
        latched_q <= latched_q | events;
    end
  end

  // interrupt enable register
  // only the low four bits exist; other offsets ignore writes
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      irq_en_q <= 4'h0;
    else if (clk_en_i && reg_wr_i && reg_addr_i == bse_pkg::OFF_IRQ_ENABLE)
      irq_en_q <= reg_wdata_i[3:0];
  end

  // interrupt request from enabled flags
  // registered, so the request drops one cycle after the
  // flags clear or their enables go low
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else if (clk_en_i)
      irq_o <= |(latched_q & irq_en_q);
  end

  // live status byte
  // unused bits read as zero
  always_comb
  begin
    live_byte = bse_pkg::RST_BYTE;
    live_byte[bse_pkg::BIT_SYNC] = out_of_sync_q;
    live_byte[bse_pkg::BIT_ERRCNT] = error_count_nonzero_q;
    live_byte[bse_pkg::BIT_UPDATE] = counter_update_done_q &
                                     update_req;
  end

  // read data register; unmapped reads give zero
  // counts are read a byte at a time from the snapshot, which
  // only moves on an update, so bytes read with no update between them agree
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= bse_pkg::RST_BYTE;
    else if (clk_en_i && reg_rd_i)
    begin
      case (reg_addr_i)
        bse_pkg::OFF_LIVE_STATUS: reg_rdata_o <= live_byte;
        bse_pkg::OFF_LATCHED_STATUS: reg_rdata_o <= {4'h0, latched_q};
        bse_pkg::OFF_IRQ_ENABLE: reg_rdata_o <= {4'h0, irq_en_q};
        bse_pkg::OFF_ERR_CNT0: reg_rdata_o <= err_snap_q[7:0];
        bse_pkg::OFF_ERR_CNT1: reg_rdata_o <= err_snap_q[15:8];
        bse_pkg::OFF_ERR_CNT2: reg_rdata_o <= err_snap_q[23:16];
        bse_pkg::OFF_BIT_CNT0: reg_rdata_o <= received_bit_count_q[7:0];
        bse_pkg::OFF_BIT_CNT1: reg_rdata_o <= received_bit_count_q[15:8];
        bse_pkg::OFF_BIT_CNT2: reg_rdata_o <= received_bit_count_q[23:16];
        bse_pkg::OFF_BIT_CNT3: reg_rdata_o <= received_bit_count_q[31:24];
        default: reg_rdata_o <= bse_pkg::RST_BYTE;
      endcase
    end
  end

endmodule : bse_core

// File: inc/bse_pkg.sv
// package for the tester status and error insertion block
// assumes a byte-wide register port on one 100 MHz clock
package bse_pkg;
  // register offsets
  localparam logic [7:0] OFF_LIVE_STATUS = 8'h0c;
  localparam logic [7:0] OFF_LATCHED_STATUS = 8'h0e;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OFF_ERR_CNT0 = 8'h14;
  localparam logic [7:0] OFF_ERR_CNT1 = 8'h15;
  localparam logic [7:0] OFF_ERR_CNT2 = 8'h16;
  localparam logic [7:0] OFF_BIT_CNT0 = 8'h18;
  localparam logic [7:0] OFF_BIT_CNT1 = 8'h19;
  localparam logic [7:0] OFF_BIT_CNT2 = 8'h1a;
  localparam logic [7:0] OFF_BIT_CNT3 = 8'h1b;
  // status field positions
  localparam int BIT_SYNC = 0;
  localparam int BIT_ERRCNT = 1;
  localparam int BIT_BITERR = 2;
  localparam int BIT_UPDATE = 3;
  // control bit positions on the control input byte
  localparam int BIT_SRC_SEL = 0;
  localparam int BIT_SW_INS = 1;
  localparam int BIT_SE_EN = 2;
  // reset value and counter limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] ERR_MAX = 24'hff_ffff;
  localparam logic [31:0] BIT_MAX = 32'hffff_ffff;
endpackage : bse_pkg

// File: bench/bse_checker.sv
// port checker for the tester status and insertion block
// bound to bse_core; one clock, synchronous active-low reset
module bse_checker
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] insert_ctrl_i,
  input wire logic ext_error_insert_input_i,
  input wire logic update_request_source_i,
  input wire logic local_update_request_i,
  input wire logic remote_update_request_i,
  input wire logic tx_bit_valid_i,
  input wire logic tx_data_i,
  input wire logic tx_data_o,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_error_i,
  input wire logic rx_out_of_sync_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [3:0] en_q; // shadow of the enable register
  logic [3:0] qc_q; // cycles without any flag source
  // mirror enable writes
  always_ff @(posedge core_clk_i)
    if (!nrst_i) en_q <= 4'h0;
    else if (reg_wr_i && reg_addr_i == 8'h10) en_q <= reg_wdata_i[3:0];
  // count quiet cycles, saturating
  always_ff @(posedge core_clk_i)
    if (!nrst_i || rx_bit_valid_i || reg_wr_i || $changed(rx_out_of_sync_i)
        || $changed(local_update_request_i)
        || $changed(remote_update_request_i)
        || $changed(update_request_source_i)) qc_q <= 4'h0;
    else if (qc_q != 4'hf) qc_q <= qc_q + 4'h1;
  sequence s_rd(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_q;
    !insert_ctrl_i[1] && !ext_error_insert_input_i;
  endsequence
  sequence s_calm;
    qc_q > 4'h5 ##1 qc_q > 4'h6 ##1 qc_q > 4'h7;
  endsequence
  AST_TX_PASS: assert property (
    s_q[*6] ##0 tx_bit_valid_i ##1 s_q ##1 (s_q and tx_bit_valid_i)
    |=> tx_data_o == $past(tx_data_i)) else $error("bit flipped unasked");
  AST_IRQ_MASKED: assert property (
    en_q == 4'h0 && $past(en_q) == 4'h0 |-> !irq_o)
    else $error("irq while all masked");
  AST_IRQ_DROP: assert property (
    s_rd(8'h0e) ##0 s_calm |-> !irq_o) else $error("irq kept after read");
  AST_EN_READBACK: assert property (
    s_rd(8'h10) ##0 !reg_wr_i |=> reg_rdata_o == {4'h0, $past(en_q)})
    else $error("enable readback wrong");
  AST_OOS_LIVE: assert property (
    $stable(rx_out_of_sync_i)[*3] ##0 s_rd(8'h0c)
    |=> reg_rdata_o[0] == $past(rx_out_of_sync_i)) else $error("sync bit");
  AST_OOS_IRQ: assert property (
    en_q[0] && $changed(rx_out_of_sync_i) && !reg_rd_i ##1 en_q[0]
    |-> ##[0:2] irq_o) else $error("no irq on sync change");
  AST_UPD_IRQ: assert property (
    !update_request_source_i && $rose(local_update_request_i) ##0 en_q[3]
    ##1 en_q[3][*2] |-> ##[0:2] irq_o) else $error("no irq on update");
  AST_ERR_IRQ: assert property (
    en_q[2] && rx_bit_valid_i && rx_bit_error_i && !rx_out_of_sync_i
    ##1 en_q[2] |-> ##[0:2] irq_o) else $error("no irq on bit error");
endmodule : bse_checker
bind bse_core bse_checker bse_checker_i (.*);

// File: bench/bse_rx_model.sv
// receive checker model: bit stream, error marks, sync level
// driven by task calls from the bench, changes at falling edges
module bse_rx_model
(
  input wire logic clk_i,
  output logic valid_o,
  output logic err_o,
  output logic oos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    valid_o = 1'b0;
    err_o = 1'b0;
    oos_o = 1'b0;
  end
  // one bit every other cycle, error where the mask bit is set
  task burst(input int n, input logic [7:0] em);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      valid_o = 1'b1;
      err_o = em[i];
      @(negedge clk_i);
      valid_o = 1'b0;
      err_o = ~err_o; // unqualified, so no held value
    end
  endtask : burst
  // move the sync level
  task set_oos(input logic o);
    @(negedge clk_i);
    oos_o = o;
  endtask : set_oos
endmodule : bse_rx_model

// File: bench/bse_core_tb.sv
// self-checking bench for the tester status and insertion block
// inputs change at falling edges; one 100 MHz clock
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module bse_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, rd, wr, ext, src, loc, rem, txv, txo, rxv, rxe, out_of_sync, irq;
  logic [7:0] addr, wd, rdat, ctrl;
  logic txd; // tx data fed to the block
  logic [7:0] offs [10] = '{8'h0c, 8'h0e, 8'h10, 8'h14, 8'h15, 8'h16,
    8'h18, 8'h19, 8'h1a, 8'h1b};
  int fail_count = 0;
  int n_compared = 0;
  bse_core bse_core_i
  (
    .core_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .reg_addr_i(addr),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .insert_ctrl_i(ctrl), .ext_error_insert_input_i(ext),
    .update_request_source_i(src), .local_update_request_i(loc),
    .remote_update_request_i(rem), .tx_bit_valid_i(txv), .tx_data_i(txd),
    .tx_data_o(txo), .rx_bit_valid_i(rxv), .rx_bit_error_i(rxe),
    .rx_out_of_sync_i(out_of_sync), .irq_o(irq)
  );
  bse_rx_model bse_rx_model_i
  (
    .clk_i(clk), .valid_o(rxv), .err_o(rxe), .oos_o(out_of_sync)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude;
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wd = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  // read and compare, data settled one cycle after the strobe
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    `CHK($sformatf("reg %h", a), e, rdat)
  endtask : rc
  // pulse the control byte from a to b n times, then count flipped tx bits of six
  task ins(input logic [7:0] a, b, input int n, input logic e, x);
    int k;
    k = 0;
    ctrl = a;
    repeat (3) @(negedge clk);
    repeat (n)
    begin
      ctrl = b;
      @(negedge clk);
      ctrl = a;
      @(negedge clk);
    end
    ext = e;
    repeat (6) @(negedge clk);
    repeat (6)
    begin
      txv = 1'b1;
      txd = ~txd;
      @(negedge clk);
      txv = 1'b0;
      @(negedge clk);
      if (txo !== txd) k++;
    end
    ext = 1'b0;
    repeat (4) @(negedge clk);
    ctrl = 8'h00;
    @(negedge clk);
    `CHK("flips", x, k)
  endtask : ins
  initial
  begin
    {nrst, rd, wr, ext, src, loc, rem, txv} = 8'h00;
    {addr, wd, ctrl} = 24'h00_0000;
    txd = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    foreach (offs[i]) rc(offs[i], 8'h00);
    rc(8'h11, 8'h00);
    wr_reg(8'h0c, 8'hff);
    rc(8'h0c, 8'h00);
    wr_reg(8'h10, 8'hff);
    rc(8'h10, 8'h0f);
    bse_rx_model_i.burst(5, 8'h12);
    loc = 1'b1;
    repeat (4) @(negedge clk);
    rc(8'h14, 8'h02);
    rc(8'h18, 8'h05);
    rc(8'h1b, 8'h00);
    rc(8'h0c, 8'h0a);
    `CHK("irq", 1'b1, irq)
    rc(8'h0e, 8'h0e);
    @(negedge clk);
    `CHK("irq", 1'b0, irq)
    rc(8'h0e, 8'h00);
    loc = 1'b0;
    repeat (2) @(negedge clk);
    rc(8'h0c, 8'h02);
    src = 1'b1;
    bse_rx_model_i.set_oos(1'b1);
    bse_rx_model_i.burst(4, 8'h0f);
    rem = 1'b1;
    repeat (6) @(negedge clk);
    rc(8'h14, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h0c, 8'h09);
    rc(8'h0e, 8'h09);
    bse_rx_model_i.set_oos(1'b0);
    rc(8'h0e, 8'h01);
    rem = 1'b0;
    repeat (5) @(negedge clk);
    rc(8'h0c, 8'h00);
    wr_reg(8'h10, 8'h00);
    bse_rx_model_i.set_oos(1'b1);
    repeat (3) @(negedge clk);
    `CHK("irq", 1'b0, irq)
    ins(8'h04, 8'h06, 1, 1'b0, 1'b1);
    ins(8'h00, 8'h02, 1, 1'b0, 1'b0);
    ins(8'h04, 8'h06, 2, 1'b0, 1'b1);
    ins(8'h05, 8'h07, 1, 1'b1, 1'b1);
    ins(8'h04, 8'h04, 0, 1'b1, 1'b0);
    conclude;
  end
  // cut a hang short
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude;
  end
endmodule : bse_core_tb
